//--- common/nio_defines.vh
// Register map, field positions, reset values and timing counts of the nibble I/O block.
// Assumes a Wishbone slave decoding word index = byte address / 4.
`ifndef NIO_DEFINES_VH
`define NIO_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define NIO_IDX_E_DIR      6'h01
`define NIO_IDX_A_DIR      6'h02
`define NIO_IDX_A_VAL      6'h03
`define NIO_IDX_C_VAL      6'h04
`define NIO_IDX_B_DIR      6'h05
`define NIO_IDX_B_VAL      6'h06
`define NIO_IDX_D_DIR      6'h0C
`define NIO_IDX_D_VAL      6'h0D
`define NIO_IDX_E_VAL      6'h0E
`define NIO_IDX_CTRL       6'h11
`define NIO_IDX_WAKE_BASE  6'h20
`define NIO_IDX_SPD_BASE   6'h24
`define NIO_IDX_WPD_BASE   6'h28
`define NIO_IDX_OPT        6'h2C

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define NIO_CTRL_FMT_BIT   1
`define NIO_CTRL_HYS_BIT   2
`define NIO_OPT_CARR_BIT   0
`define NIO_OPT_BOTH_BIT   1
`define NIO_OPT_RSTB_BIT   2
`define NIO_OPT_RSTC_BIT   3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define NIO_DIR_RST        4'h0
`define NIO_VAL_RST        4'h0
`define NIO_CTRL_RST       4'h0
`define NIO_OPT_RST        4'h0
`define NIO_WAKE_VECTOR    12'h004

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define NIO_CLK_HZ         100000000
`define NIO_CARRIER_HZ     38000
`define NIO_CARRIER_HALF   (`NIO_CLK_HZ / (2 * `NIO_CARRIER_HZ))

`endif

//--- logic/nio_ports.v
// Nibble I/O ports: four bidirectional ports A, B, D, E, output port C,
// carrier on port A pin 3, hysteresis select, pin reset options, HALT wake.
// Assumes a classic Wishbone master on clk_i and pads resolved outside.
//
// Functional notes
// - Direction bit one is output, resets input
// - Output pins drive latch; reads return latch
// - Pull-downs removed while pin is output; kept on A3 when HALT forces it out
// - Input reads pad level; optional pull-down
// - Rising edge in HALT wakes, vector 0x004
// - Both-edge option adds falling-edge wake
// - Per-port wake masks; port C none
// - Carrier on, output, bit one: 38 kHz
// - Carrier on, output, bit zero: low
// - HALT forces port A pin 3 low
// - Carrier off: pin 3 ordinary
// - One bit selects hysteresis for all
// - Port C output only, resets zero
// - Port B behaves like port A
// - Port D direction, pull-downs inputs only
// - Port E direction, pull-downs inputs only
// - Separate strong and weak pull-down masks
// - B3 and C3 optional reset, pull-up
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "nio_defines.vh"

module nio_ports (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        halt_i,
    output reg         wake_o,
    output reg  [11:0] wake_pc_o,
    input  wire [15:0] pad_in_i,
    output reg  [15:0] pad_out_o,
    output reg  [15:0] pad_oe_o,
    output reg  [15:0] strong_pd_o,
    output reg  [15:0] weak_pd_o,
    output reg         hysteresis_input_select_o,
    output reg         audio_twos_complement_format_o,
    input  wire        portc_pin3_i,
    output reg  [3:0]  portc_out_o,
    output reg  [3:0]  portc_oe_o,
    output reg  [1:0]  reset_pullup_o,
    output reg         ext_reset_o
);

    // ------------------------------------------------------------------------
    // Decode helpers: {hit, port} with port 0=A 1=B 2=D 3=E
    // ------------------------------------------------------------------------
    function [2:0] dec_dir;
        input [5:0] a;
        begin
            case (a)
                `NIO_IDX_A_DIR: dec_dir = 3'h4;
                `NIO_IDX_B_DIR: dec_dir = 3'h5;
                `NIO_IDX_D_DIR: dec_dir = 3'h6;
                `NIO_IDX_E_DIR: dec_dir = 3'h7;
                default:        dec_dir = 3'h0;
            endcase
        end
    endfunction

    function [2:0] dec_val;
        input [5:0] a;
        begin
            case (a)
                `NIO_IDX_A_VAL: dec_val = 3'h4;
                `NIO_IDX_B_VAL: dec_val = 3'h5;
                `NIO_IDX_D_VAL: dec_val = 3'h6;
                `NIO_IDX_E_VAL: dec_val = 3'h7;
                default:        dec_val = 3'h0;
            endcase
        end
    endfunction

    // Wake and pull-down groups: {hit, port}, base aligned to four
    function [2:0] dec_grp;
        input [5:0] a;
        input [5:0] base;
        begin
            if (a[5:2] == base[5:2]) begin
                dec_grp = {1'b1, a[1:0]};
            end else begin
                dec_grp = 3'h0;
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg [15:0] dir_r;
    reg [15:0] val_r;
    reg [15:0] wake_r;
    reg [15:0] spd_r;
    reg [15:0] wpd_r;
    reg [3:0]  portc_r;
    reg        hys_r;
    reg        fmt_r;
    reg [3:0]  opt_r;
    reg [15:0] carr_cnt_r;
    reg        carr_r;
    reg [15:0] meta_r;
    reg [15:0] s2_r;
    reg [15:0] s3_r;
    reg [15:0] pin_r;
    reg [2:0]  c3_sync_r;
    reg        c3_pin_r;

    wire [5:0] idx    = wb_adr_i[7:2];
    wire       req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr     = req & wb_we_i & wb_sel_i[0];
    wire [2:0] d_dir  = dec_dir(idx);
    wire [2:0] d_val  = dec_val(idx);
    wire [2:0] d_wake = dec_grp(idx, `NIO_IDX_WAKE_BASE);
    wire [2:0] d_spd  = dec_grp(idx, `NIO_IDX_SPD_BASE);
    wire [2:0] d_wpd  = dec_grp(idx, `NIO_IDX_WPD_BASE);
    wire [3:0] wd     = wb_dat_i[3:0];

    wire carrier_on = opt_r[`NIO_OPT_CARR_BIT];
    wire both_edge  = opt_r[`NIO_OPT_BOTH_BIT];
    wire rst_pin_b  = opt_r[`NIO_OPT_RSTB_BIT];
    wire rst_pin_c  = opt_r[`NIO_OPT_RSTC_BIT];

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            dir_r   <= {4{`NIO_DIR_RST}};
            val_r   <= {4{`NIO_VAL_RST}};
            wake_r  <= 16'h0000;
            spd_r   <= 16'h0000;
            wpd_r   <= 16'h0000;
        end else if (wr) begin
            if (d_dir[2]) begin
                dir_r[d_dir[1:0]*4 +: 4] <= wd;
            end
            if (d_val[2]) begin
                val_r[d_val[1:0]*4 +: 4] <= wd;
            end
            if (d_wake[2]) begin
                wake_r[d_wake[1:0]*4 +: 4] <= wd;
            end
            if (d_spd[2]) begin
                spd_r[d_spd[1:0]*4 +: 4] <= wd;
            end
            if (d_wpd[2]) begin
                wpd_r[d_wpd[1:0]*4 +: 4] <= wd;
            end
        end
    end

    // Single registers: port C, control, options
    always @(posedge clk_i) begin
        if (rst_i) begin
            portc_r <= `NIO_VAL_RST;
            hys_r   <= 1'b0;
            fmt_r   <= 1'b0;
            opt_r   <= `NIO_OPT_RST;
        end else if (wr) begin
            if (idx == `NIO_IDX_C_VAL) begin
                portc_r <= wd;
            end
            if (idx == `NIO_IDX_CTRL) begin
                hys_r <= wd[`NIO_CTRL_HYS_BIT];
                fmt_r <= wd[`NIO_CTRL_FMT_BIT];
            end
            if (idx == `NIO_IDX_OPT) begin
                opt_r <= wd;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Bus answer: one wait state, unmapped reads zero
    // ------------------------------------------------------------------------
    reg [3:0] rd_nib;
    always @* begin
        rd_nib = 4'h0;
        if (d_dir[2]) begin
            rd_nib = dir_r[d_dir[1:0]*4 +: 4];
        end else if (d_val[2]) begin
            // Outputs return latch, inputs return pad
            rd_nib = (dir_r[d_val[1:0]*4 +: 4] & val_r[d_val[1:0]*4 +: 4])
                   | (~dir_r[d_val[1:0]*4 +: 4] & pin_r[d_val[1:0]*4 +: 4]);
        end else if (d_wake[2]) begin
            rd_nib = wake_r[d_wake[1:0]*4 +: 4];
        end else if (d_spd[2]) begin
            rd_nib = spd_r[d_spd[1:0]*4 +: 4];
        end else if (d_wpd[2]) begin
            rd_nib = wpd_r[d_wpd[1:0]*4 +: 4];
        end else if (idx == `NIO_IDX_C_VAL) begin
            rd_nib = portc_r;
        end else if (idx == `NIO_IDX_CTRL) begin
            rd_nib = {1'b0, hys_r, fmt_r, 1'b0};
        end else if (idx == `NIO_IDX_OPT) begin
            rd_nib = opt_r;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Read data stands beside ack only
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= req ? {28'h0000000, rd_nib} : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers: change counts once stages two and three agree
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 16'h0000;
            s2_r   <= 16'h0000;
            s3_r   <= 16'h0000;
            pin_r  <= 16'h0000;
        end else begin
            meta_r <= pad_in_i;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
            pin_r  <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
        end
    end

    // Port C pin 3 reset input, starts at its pulled-up idle level
    always @(posedge clk_i) begin
        if (rst_i) begin
            c3_sync_r <= 3'h7;
            c3_pin_r  <= 1'b1;
        end else begin
            c3_sync_r <= {c3_sync_r[1:0], portc_pin3_i};
            if (c3_sync_r[1] == c3_sync_r[2]) begin
                c3_pin_r <= c3_sync_r[2];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Carrier divider
    // ------------------------------------------------------------------------
    localparam integer CARR_LAST_I = `NIO_CARRIER_HALF - 1;
    localparam [15:0]  CARR_LAST   = CARR_LAST_I[15:0];
    always @(posedge clk_i) begin
        if (rst_i) begin
            carr_cnt_r <= 16'h0000;
            carr_r     <= 1'b0;
        end else if (carr_cnt_r == CARR_LAST) begin
            carr_cnt_r <= 16'h0000;
            carr_r     <= ~carr_r;
        end else begin
            carr_cnt_r <= carr_cnt_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Per-pin output, enable and pull-down
    // ------------------------------------------------------------------------
    wire [15:0] out_nxt;
    wire [15:0] oe_nxt;
    wire [15:0] spd_nxt;
    wire [15:0] wpd_nxt;
    wire [15:0] rise;
    wire [15:0] fall;
    reg  [15:0] pin_d_r;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_pin
            // Port B pin 3 may be taken over as a reset input
            wire is_rst = (g == 7) && rst_pin_b;
            wire is_c3  = (g == 3) && carrier_on;
            wire hlt_c3 = (g == 3) && halt_i;
            assign oe_nxt[g] = hlt_c3 | (dir_r[g] & ~is_rst);
            assign out_nxt[g] = hlt_c3 ? 1'b0 :
                                is_c3 ? (val_r[g] & carr_r) :
                                val_r[g];
            assign spd_nxt[g] = spd_r[g] & ~dir_r[g] & ~is_rst;
            assign wpd_nxt[g] = wpd_r[g] & ~dir_r[g] & ~is_rst;
            assign rise[g] = pin_r[g] & ~pin_d_r[g];
            assign fall[g] = ~pin_r[g] & pin_d_r[g];
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            pad_out_o   <= 16'h0000;
            pad_oe_o    <= 16'h0000;
            strong_pd_o <= 16'h0000;
            weak_pd_o   <= 16'h0000;
        end else begin
            pad_out_o   <= out_nxt;
            pad_oe_o    <= oe_nxt;
            strong_pd_o <= spd_nxt;
            weak_pd_o   <= wpd_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Port C and reset pin options
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            portc_out_o    <= 4'h0;
            portc_oe_o     <= 4'hF;
            reset_pullup_o <= 2'h0;
            ext_reset_o    <= 1'b0;
        end else begin
            portc_out_o    <= portc_r;
            portc_oe_o     <= {~rst_pin_c, 3'h7};
            reset_pullup_o <= {rst_pin_c, rst_pin_b};
            ext_reset_o    <= (rst_pin_b & ~pin_r[7]) | (rst_pin_c & ~c3_pin_r);
        end
    end

    // ------------------------------------------------------------------------
    // Control bits to the pad buffers and the audio path
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            hysteresis_input_select_o      <= 1'b0;
            audio_twos_complement_format_o <= 1'b0;
        end else begin
            hysteresis_input_select_o      <= hys_r;
            audio_twos_complement_format_o <= fmt_r;
        end
    end

    // ------------------------------------------------------------------------
    // HALT wake on masked pin edges
    // ------------------------------------------------------------------------
    // Previous pin level for edge detection
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_d_r <= 16'h0000;
        end else begin
            pin_d_r <= pin_r;
        end
    end

    wire [15:0] edge_hit = (rise | (fall & {16{both_edge}})) & wake_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_o    <= 1'b0;
            wake_pc_o <= 12'h000;
        end else begin
            wake_o  <= halt_i & (|edge_hit);
            if (halt_i & (|edge_hit)) begin
                wake_pc_o <= `NIO_WAKE_VECTOR;
            end
        end
    end

endmodule

`default_nettype wire

//--- bench/nio_ports_monitor.sv
// Checker for the nibble I/O block: bus answer, pull-downs, halt, wake, port C.
// Assumes it is bound to nio_ports and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
`include "nio_defines.vh"
module nio_ports_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_ack_o,
    input wire logic        halt_i,
    input wire logic        wake_o,
    input wire logic [11:0] wake_pc_o,
    input wire logic [15:0] pad_out_o,
    input wire logic [15:0] pad_oe_o,
    input wire logic [15:0] strong_pd_o,
    input wire logic [15:0] weak_pd_o,
    input wire logic        hysteresis_input_select_o,
    input wire logic [3:0]  portc_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic wr_c = req_w & wb_we_i & wb_sel_i[0] & (wb_adr_i[7:2] == `NIO_IDX_C_VAL);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence req_s; req_w; endsequence
    sequence halt_s; halt_i [*3]; endsequence
    bus_answer_a: assert property (req_s |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    pd_off_a: assert property (((strong_pd_o | weak_pd_o) & pad_oe_o & 16'hFFF7) == 16'h0000)
        else $error("pull-down left on an output pin");
    halt_low_a: assert property (halt_s |-> pad_oe_o[3] && !pad_out_o[3])
        else $error("port A pin 3 not driven low in halt");
    wake_halt_a: assert property (wake_o |-> $past(halt_i))
        else $error("wake outside halt");
    wake_vec_a: assert property (wake_o |=> wake_pc_o == `NIO_WAKE_VECTOR)
        else $error("wrong wake vector");
    wake_pulse_a: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    reset_state_a: assert property ($fell(rst_i) |-> pad_oe_o == 16'h0000
        && portc_out_o == 4'h0 && !hysteresis_input_select_o)
        else $error("outputs not at reset state");
    portc_write_a: assert property ($changed(portc_out_o) |-> $past(wr_c) || $past(wr_c, 2))
        else $error("port C changed without a write");
endmodule
bind nio_ports nio_ports_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_ack_o, .halt_i, .wake_o, .wake_pc_o, .pad_out_o, .pad_oe_o,
    .strong_pd_o, .weak_pd_o, .hysteresis_input_select_o, .portc_out_o);
`default_nettype wire

//--- bench/nio_pins.sv
// Pads outside the nibble I/O block: outside drivers, pull resistors, loads.
// Assumes the bench sets drv_i and en_i for pins it drives itself.
`timescale 1ns/10ps
`default_nettype none
module nio_pins (
    input  wire logic [15:0] out_i,
    input  wire logic [15:0] oe_i,
    input  wire logic [15:0] pd_i,
    input  wire logic [15:0] drv_i,
    input  wire logic [15:0] en_i,
    input  wire logic        pu_i,
    output logic [15:0]      pin_o
);
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (oe_i[i]) pin_o[i] = out_i[i];
            else if (en_i[i]) pin_o[i] = drv_i[i];
            else if (pd_i[i]) pin_o[i] = 1'b0;
            else if (i == 7 && pu_i) pin_o[i] = 1'b1;
            else pin_o[i] = ~out_i[i];
        end
    end
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for nio_ports: Wishbone tasks, one task per scenario.
// Assumes nio_pins models the pads and the checker is bound to uut.
`timescale 1ns/10ps
`default_nettype none
`include "nio_defines.vh"
module tb;
    logic        clk_i, rst_i, cyc, stb, we, halt, c3, wb_ack_o, wake_o, hys, ext_rst, fmt;
    logic [7:0]  adr;
    logic [31:0] dat, wb_dat_o;
    logic [15:0] drv, en, pad_in, pad_out_o, pad_oe_o, strong_pd_o, weak_pd_o;
    logic [11:0] wake_pc_o;
    logic [3:0]  portc_out_o, pc_oe;
    logic [1:0]  pull;
    int          err_total, cmp_count;
    nio_ports uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .halt_i(halt), .wake_o(wake_o), .wake_pc_o(wake_pc_o),
        .pad_in_i(pad_in), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
        .strong_pd_o(strong_pd_o), .weak_pd_o(weak_pd_o), .hysteresis_input_select_o(hys),
        .audio_twos_complement_format_o(fmt), .portc_pin3_i(c3), .portc_out_o(portc_out_o),
        .portc_oe_o(pc_oe), .reset_pullup_o(pull), .ext_reset_o(ext_rst));
    nio_pins pins (.out_i(pad_out_o), .oe_i(pad_oe_o), .pd_i(strong_pd_o | weak_pd_o),
        .drv_i(drv), .en_i(en), .pu_i(pull[0]), .pin_o(pad_in));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] ix, input logic [3:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {ix, 2'b00};
        dat <= {28'h0000000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        {cyc, stb, we} <= 3'b000;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask
    task automatic gap(output int n);
        logic v;
        v = pad_out_o[3];
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pad_out_o[3] === v && n < 3000);
    endtask
    task automatic pin(input int i, input logic v, output logic f);
        @(posedge clk_i);
        drv[i] <= v;
        f = 1'b0;
        repeat (20) begin
            @(posedge clk_i);
            if (wake_o === 1'b1) f = 1'b1;
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [5:0]  ix [0:6];
        logic [31:0] r;
        ix = '{`NIO_IDX_E_DIR, `NIO_IDX_A_DIR, `NIO_IDX_C_VAL, `NIO_IDX_B_DIR,
               `NIO_IDX_D_DIR, `NIO_IDX_CTRL, 6'h3F};
        wb(1'b1, 6'h3F, 4'hF, r);
        foreach (ix[i]) begin
            wb(1'b0, ix[i], 4'h0, r);
            chk(r, 32'h0);
        end
        chk({16'h0, pad_oe_o}, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_ports();
        logic [5:0]  di [0:3];
        logic [5:0]  vi [0:3];
        logic [31:0] r;
        di = '{`NIO_IDX_A_DIR, `NIO_IDX_B_DIR, `NIO_IDX_D_DIR, `NIO_IDX_E_DIR};
        vi = '{`NIO_IDX_A_VAL, `NIO_IDX_B_VAL, `NIO_IDX_D_VAL, `NIO_IDX_E_VAL};
        drv <= 16'h8888;
        en <= 16'hFFFF;
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, di[p], 4'h5, r);
            wb(1'b1, vi[p], 4'hF, r);
            wb(1'b1, `NIO_IDX_SPD_BASE + 6'(p), 4'hF, r);
            wb(1'b1, `NIO_IDX_WPD_BASE + 6'(p), 4'h3, r);
            repeat (6) @(posedge clk_i);
            wb(1'b0, vi[p], 4'h0, r);
            chk(r, 32'hD);
            chk({28'h0, pad_oe_o[p*4 +: 4]}, 32'h5);
            chk({28'h0, pad_out_o[p*4 +: 4] & 4'h5}, 32'h5);
            chk({28'h0, strong_pd_o[p*4 +: 4]}, 32'hA);
            chk({28'h0, weak_pd_o[p*4 +: 4]}, 32'h2);
            en[p*4+3] <= 1'b0;
            repeat (6) @(posedge clk_i);
            wb(1'b0, vi[p], 4'h0, r);
            chk(r, 32'h5);
            en[p*4+3] <= 1'b1;
            wb(1'b1, di[p], 4'h0, r);
        end
        $display("ports test done");
    endtask
    task automatic t_misc();
        logic [31:0] r;
        drv[7] <= 1'b0;
        wb(1'b1, `NIO_IDX_C_VAL, 4'h9, r);
        wb(1'b1, `NIO_IDX_CTRL, 4'hF, r);
        wb(1'b1, `NIO_IDX_OPT, 4'h4, r);
        wb(1'b0, `NIO_IDX_CTRL, 4'h0, r);
        chk(r, 32'h6);
        repeat (6) @(posedge clk_i);
        chk({28'h0, portc_out_o}, 32'h9);
        chk({31'h0, hys}, 32'h1);
        chk({30'h0, pull}, 32'h1);
        chk({31'h0, ext_rst}, 32'h1);
        chk({31'h0, fmt}, 32'h1);
        chk({28'h0, pc_oe}, 32'hF);
        wb(1'b1, `NIO_IDX_OPT, 4'h8, r);
        repeat (8) @(posedge clk_i);
        chk({28'h0, pc_oe}, 32'h7);
        chk({30'h0, pull}, 32'h2);
        chk({31'h0, ext_rst}, 32'h0);
        c3 <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({31'h0, ext_rst}, 32'h1);
        c3 <= 1'b1;
        wb(1'b1, `NIO_IDX_OPT, 4'h0, r);
        $display("misc test done");
    endtask
    task automatic t_carrier();
        logic [31:0] r;
        int n;
        wb(1'b1, `NIO_IDX_A_DIR, 4'h8, r);
        wb(1'b1, `NIO_IDX_A_VAL, 4'h8, r);
        wb(1'b1, `NIO_IDX_OPT, 4'h1, r);
        gap(n);
        gap(n);
        gap(n);
        chk(n, `NIO_CARRIER_HALF);
        wb(1'b1, `NIO_IDX_A_VAL, 4'h0, r);
        repeat (2) @(posedge clk_i);
        gap(n);
        chk(n, 3000);
        chk({31'h0, pad_out_o[3]}, 32'h0);
        wb(1'b1, `NIO_IDX_OPT, 4'h0, r);
        wb(1'b1, `NIO_IDX_A_VAL, 4'h8, r);
        repeat (2) @(posedge clk_i);
        chk({31'h0, pad_out_o[3]}, 32'h1);
        halt <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({31'h0, pad_out_o[3]}, 32'h0);
        halt <= 1'b0;
        wb(1'b1, `NIO_IDX_A_DIR, 4'h0, r);
        $display("carrier test done");
    endtask
    task automatic t_wake();
        logic [31:0] r;
        logic f;
        wb(1'b1, `NIO_IDX_WAKE_BASE, 4'h1, r);
        drv <= 16'h0000;
        halt <= 1'b1;
        repeat (8) @(posedge clk_i);
        pin(0, 1'b1, f);
        chk({31'h0, f}, 32'h1);
        chk({20'h0, wake_pc_o}, 32'h4);
        pin(4, 1'b1, f);
        chk({31'h0, f}, 32'h0);
        pin(0, 1'b0, f);
        chk({31'h0, f}, 32'h0);
        wb(1'b1, `NIO_IDX_OPT, 4'h2, r);
        pin(0, 1'b1, f);
        pin(0, 1'b0, f);
        chk({31'h0, f}, 32'h1);
        halt <= 1'b0;
        $display("wake test done");
    endtask
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, halt, c3} = 5'b00001;
        {adr, dat, drv, en} = '0;
        err_total = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_ports();
        t_misc();
        t_carrier();
        t_wake();
        end_of_test();
    end
endmodule
`default_nettype wire
